// file: include/ssc_pkg.sv
// Constants, types and helpers shared by the startup sequencer.
package ssc_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int POR_DELAY_NS  = 20_000_000;  // 20 ms after supply good.
  localparam int POR_CYC       = POR_DELAY_NS / CLK_PERIOD_NS;
  localparam int LOCK_WAIT_NS  = 1_000_000;   // 1 ms PLL lock wait.
  localparam int LOCK_CYC      = LOCK_WAIT_NS / CLK_PERIOD_NS;
  localparam int I2C_QTR_NS    = 625;         // Quarter of a 400 kHz bit.
  localparam int I2C_QTR_CYC   = (I2C_QTR_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam logic [7:0] QTR_LAST      = 8'(I2C_QTR_CYC - 1);
  localparam logic [3:0] DIV_ALIGN_CYC = 4'h8;

  // ----------------------------------------------------------------------
  // Register image and serial memory transfer
  // ----------------------------------------------------------------------
  localparam int              NUM_REGS       = 16;
  localparam logic [15:0]     CFG_BASE_ADDR  = 16'h02fc;
  localparam logic [15:0]     GPIO_CFG_FIRST = 16'h0300;
  localparam logic [15:0]     GPIO_CFG_LAST  = 16'h0303;
  localparam logic [3:0]      REG_OE_LO      = 4'h0;
  localparam logic [3:0]      REG_OE_HI      = 4'h1;
  localparam logic [3:0]      REG_PLL_PWR    = 4'h2;
  localparam logic [7:0]      EE_ADDR_WR     = 8'ha0;
  localparam logic [7:0]      EE_ADDR_RD     = 8'ha1;
  localparam logic [7:0]      EE_WORD_ADDR   = 8'h00;
  localparam logic [4:0]      XFER_WR        = 5'h00;
  localparam logic [4:0]      XFER_WORD      = 5'h01;
  localparam logic [4:0]      XFER_RD        = 5'h02;
  localparam logic [4:0]      XFER_DATA0     = 5'h03;
  localparam logic [4:0]      XFER_LAST      = 5'h13;  // Checksum byte.

  // Built-in images: output enables and analog PLL power per strap code.
  localparam logic [15:0] DEF_OE  [4] = '{16'h0fff, 16'h0fff, 16'h0fff,
                                          16'h0ffb};
  localparam logic [2:0]  DEF_PWR [4] = '{3'h3, 3'h3, 3'h7, 3'h7};

  typedef enum logic [3:0] {
    S_POR   = 4'h0,
    S_START = 4'h1,
    S_BYTE  = 4'h2,
    S_STOP  = 4'h3,
    S_DEF   = 4'h4,
    S_CAL   = 4'h5,
    S_LOCK  = 4'h6,
    S_ALIGN = 4'h7,
    S_READY = 4'h8
  } ssc_state_t;

  // Byte of the built-in image for a strap code and register index.
  function automatic logic [7:0] default_byte(input logic [1:0] sel,
                                              input logic [3:0] idx);
    logic [15:0] oe;
    oe = DEF_OE[sel];
    if (idx == REG_OE_LO)
      return oe[7:0];
    else if (idx == REG_OE_HI)
      return oe[15:8];
    else if (idx == REG_PLL_PWR)
      return {5'h00, DEF_PWR[sel]};
    else
      return 8'h00;
  endfunction : default_byte

  // True when an image index lands on a pin configuration register.
  function automatic logic is_gpio_cfg(input logic [3:0] idx);
    logic [15:0] addr;
    addr = CFG_BASE_ADDR + {12'h000, idx};
    return (addr >= GPIO_CFG_FIRST) && (addr <= GPIO_CFG_LAST);
  endfunction : is_gpio_cfg

endpackage : ssc_pkg

// file: hdl/ssc_startup.sv
// Startup sequencer: reset, image load, PLL calibration, ready status.
`timescale 1ns/1ps

// Notes on behaviour
// - internal reset ends 20 ms after oscillator supply
// - after reset, probe serial memory as master
// - memory image loads, pin config registers untouched
// - no memory or bad checksum: strap default
// - default image sets output enables per code
// - calibrate only powered analog PLLs
// - wait 1 ms for lock after calibration
// - then pulse divider alignment reset
// - third status pin copies ready flag
// - straps sampled at internal reset release
// - status pins driven, ready low until done
module ssc_startup #(
  parameter int unsigned POR_CYC  = ssc_pkg::POR_CYC,
  parameter int unsigned LOCK_CYC = ssc_pkg::LOCK_CYC,
  parameter int unsigned QTR_CYC  = ssc_pkg::I2C_QTR_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        oscillator_supply_i,
  input  wire logic [1:0]  strap_sel_i,
  input  wire logic        sda_i,
  input  wire logic [2:0]  cal_done_i,
  input  wire logic        pll0_lock_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  output logic             sda_o,
  output logic             sda_oe_o,
  output logic [2:0]       cal_req_o,
  output logic             div_reset_o,
  output logic [15:0]      out_enable_o,
  output logic [2:0]       analog_pll_power_o,
  output logic             cfg_from_eeprom_o,
  output logic             init_complete_flag_o,
  output logic             status_pin_three_o,
  output logic             status_pin_two_o
);

  ssc_pkg::ssc_state_t state_reg;
  logic [22:0] por_cnt_reg;
  logic        por_done_reg;
  logic [1:0]  strap_reg;
  logic [7:0]  qtr_cnt_reg;
  logic [1:0]  q_reg;
  logic [3:0]  bit_reg;
  logic [4:0]  xfer_reg;
  logic [7:0]  rx_reg;
  logic        ack_reg;
  logic [7:0]  sum_reg;
  logic        ee_ok_reg;
  logic [3:0]  idx_reg;
  logic [22:0] wait_reg;
  logic        ready_reg;
  logic        lock_reg;
  logic        scl_low_reg;
  logic        sda_low_reg;
  logic        scl_low_next;
  logic        sda_low_next;
  logic [7:0]  cfg_mem [ssc_pkg::NUM_REGS];
  logic        tick;
  logic        is_rx;
  logic        last_xfer;
  logic        store;
  logic        seq_rst;
  logic [3:0]  data_idx;
  logic [7:0]  tx_byte;
  logic [4:0]  data_off;
  logic [2:0]  pwr;

  // ----------------------------------------------------------------------
  // Internal power-on reset and strap capture
  // ----------------------------------------------------------------------
  // The delay restarts whenever the oscillator supply drops.
  always_ff @(posedge core_clk_i)
    if (!rst_b_i || !oscillator_supply_i)
    begin
      por_cnt_reg  <= 23'h000000;
      por_done_reg <= 1'b0;
    end
    else if (!por_done_reg)
    begin
      if (por_cnt_reg == 23'(POR_CYC - 1))
        por_done_reg <= 1'b1;
      else
        por_cnt_reg <= por_cnt_reg + 23'h000001;
    end

  // Straps are caught in the cycle the internal reset releases.
  always_ff @(posedge core_clk_i)
    if (!rst_b_i)
      strap_reg <= 2'h0;
    else if (!por_done_reg && oscillator_supply_i &&
             por_cnt_reg == 23'(POR_CYC - 1))
      strap_reg <= strap_sel_i;

  assign seq_rst = !rst_b_i || !por_done_reg || !oscillator_supply_i;

  // ----------------------------------------------------------------------
  // Serial memory transfer helpers
  // ----------------------------------------------------------------------
  // Quarter-bit enable; no clock stretching is supported by the memory.
  always_ff @(posedge core_clk_i)
    if (!rst_b_i || tick)
      qtr_cnt_reg <= 8'h00;
    else
      qtr_cnt_reg <= qtr_cnt_reg + 8'h01;

  // The quarter length is a parameter so that short runs stay short.
  assign tick      = (qtr_cnt_reg == 8'(QTR_CYC - 1));
  assign is_rx     = (xfer_reg >= ssc_pkg::XFER_DATA0);
  assign last_xfer = (xfer_reg == ssc_pkg::XFER_LAST);
  assign data_off  = xfer_reg - ssc_pkg::XFER_DATA0;
  assign data_idx  = data_off[3:0];
  assign tx_byte   = (xfer_reg == ssc_pkg::XFER_WR)   ? ssc_pkg::EE_ADDR_WR
                   : (xfer_reg == ssc_pkg::XFER_WORD) ? ssc_pkg::EE_WORD_ADDR
                   : ssc_pkg::EE_ADDR_RD;
  assign store     = (state_reg == ssc_pkg::S_BYTE) && tick && q_reg == 2'h3
                     && bit_reg == 4'h8 && is_rx && !last_xfer;

  // Open-drain levels per quarter: start, data bit, stop.
  always_comb
  begin
    scl_low_next = 1'b0;
    sda_low_next = 1'b0;
    case (state_reg)
      ssc_pkg::S_START:
      begin
        scl_low_next = (q_reg == 2'h0) || (q_reg == 2'h3);
        sda_low_next = q_reg[1];
      end
      ssc_pkg::S_BYTE:
      begin
        scl_low_next = (q_reg == 2'h0) || (q_reg == 2'h3);
        if (bit_reg != 4'h8)
          sda_low_next = !is_rx && !tx_byte[3'(4'h7 - bit_reg)];
        else
          sda_low_next = is_rx && !last_xfer;
      end
      ssc_pkg::S_STOP:
      begin
        scl_low_next = (q_reg == 2'h0);
        sda_low_next = !q_reg[1];
      end
      default:
      begin
        scl_low_next = 1'b0;
        sda_low_next = 1'b0;
      end
    endcase
  end

  // Pins are registered so that no glitch reaches the bus.
  always_ff @(posedge core_clk_i)
    if (!rst_b_i)
    begin
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
    end
    else
    begin
      scl_low_reg <= scl_low_next;
      sda_low_reg <= sda_low_next;
    end

  // Data and acknowledge are sampled late in the high phase of SCL.
  always_ff @(posedge core_clk_i)
    if (!rst_b_i)
    begin
      rx_reg  <= 8'h00;
      ack_reg <= 1'b1;
    end
    else if (state_reg == ssc_pkg::S_BYTE && tick && q_reg == 2'h2)
    begin
      if (bit_reg == 4'h8)
        ack_reg <= sda_i;
      else
        rx_reg <= {rx_reg[6:0], sda_i};
    end

  // ----------------------------------------------------------------------
  // Startup sequence
  // ----------------------------------------------------------------------
  // The first write address doubles as the presence probe: a missing
  // acknowledge ends the transfer and falls back to the strap image.
  always_ff @(posedge core_clk_i)
    if (seq_rst)
    begin
      state_reg <= ssc_pkg::S_POR;
      q_reg     <= 2'h0;
      bit_reg   <= 4'h0;
      xfer_reg  <= ssc_pkg::XFER_WR;
      sum_reg   <= 8'h00;
      ee_ok_reg <= 1'b0;
      idx_reg   <= 4'h0;
      wait_reg  <= 23'h000000;
    end
    else
    begin
      if (tick)
        q_reg <= q_reg + 2'h1;
      if (store)
        sum_reg <= sum_reg + rx_reg;
      case (state_reg)
        ssc_pkg::S_POR:
        begin
          state_reg <= ssc_pkg::S_START;
          q_reg     <= 2'h0;
        end
        ssc_pkg::S_START:
          if (tick && q_reg == 2'h3)
          begin
            state_reg <= ssc_pkg::S_BYTE;
            bit_reg   <= 4'h0;
          end
        ssc_pkg::S_BYTE:
          if (tick && q_reg == 2'h3)
          begin
            if (bit_reg != 4'h8)
              bit_reg <= bit_reg + 4'h1;
            else
            begin
              bit_reg <= 4'h0;
              if (!is_rx && ack_reg)
                state_reg <= ssc_pkg::S_STOP;
              else if (xfer_reg == ssc_pkg::XFER_WORD)
              begin
                state_reg <= ssc_pkg::S_START;
                xfer_reg  <= xfer_reg + 5'h01;
              end
              else if (last_xfer)
              begin
                state_reg <= ssc_pkg::S_STOP;
                ee_ok_reg <= ((sum_reg + rx_reg) == 8'h00);
              end
              else
                xfer_reg <= xfer_reg + 5'h01;
            end
          end
        ssc_pkg::S_STOP:
          if (tick && q_reg == 2'h3)
          begin
            state_reg <= ee_ok_reg ? ssc_pkg::S_CAL : ssc_pkg::S_DEF;
            idx_reg   <= 4'h0;
          end
        ssc_pkg::S_DEF:
        begin
          idx_reg <= idx_reg + 4'h1;
          if (idx_reg == 4'hf)
            state_reg <= ssc_pkg::S_CAL;
        end
        ssc_pkg::S_CAL:
          if ((cal_done_i & pwr) == pwr)
          begin
            state_reg <= ssc_pkg::S_LOCK;
            wait_reg  <= 23'h000000;
          end
        ssc_pkg::S_LOCK:
          if (wait_reg == 23'(LOCK_CYC - 1))
          begin
            state_reg <= ssc_pkg::S_ALIGN;
            wait_reg  <= 23'h000000;
          end
          else
            wait_reg <= wait_reg + 23'h000001;
        ssc_pkg::S_ALIGN:
          if (wait_reg == 23'({19'h00000, ssc_pkg::DIV_ALIGN_CYC} - 1))
            state_reg <= ssc_pkg::S_READY;
          else
            wait_reg <= wait_reg + 23'h000001;
        default:
          state_reg <= ssc_pkg::S_READY;
      endcase
    end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  // A failed load leaves partial bytes that the default pass overwrites.
  always_ff @(posedge core_clk_i)
    if (!rst_b_i)
    begin
      for (int i = 0; i < ssc_pkg::NUM_REGS; i++)
        cfg_mem[i] <= 8'h00;
    end
    else if (store && !ssc_pkg::is_gpio_cfg(data_idx))
      cfg_mem[data_idx] <= rx_reg;
    else if (state_reg == ssc_pkg::S_DEF)
      cfg_mem[idx_reg] <= ssc_pkg::default_byte(strap_reg, idx_reg);

  // ----------------------------------------------------------------------
  // Status and outputs
  // ----------------------------------------------------------------------
  // Ready follows the first cycle spent in the final state.
  always_ff @(posedge core_clk_i)
    if (seq_rst)
    begin
      ready_reg <= 1'b0;
      lock_reg  <= 1'b0;
    end
    else
    begin
      ready_reg <= (state_reg == ssc_pkg::S_READY);
      lock_reg  <= pll0_lock_i;
    end

  assign pwr                  = cfg_mem[ssc_pkg::REG_PLL_PWR][2:0];
  assign cal_req_o            = (state_reg == ssc_pkg::S_CAL) ? pwr : 3'h0;
  assign div_reset_o          = (state_reg == ssc_pkg::S_ALIGN);
  assign out_enable_o         = {cfg_mem[ssc_pkg::REG_OE_HI],
                                 cfg_mem[ssc_pkg::REG_OE_LO]};
  assign analog_pll_power_o   = pwr;
  assign cfg_from_eeprom_o    = ee_ok_reg;
  assign init_complete_flag_o = ready_reg;
  assign status_pin_three_o   = ready_reg;
  assign status_pin_two_o     = lock_reg;
  assign scl_o                = 1'b0;
  assign scl_oe_o             = scl_low_reg;
  assign sda_o                = 1'b0;
  assign sda_oe_o             = sda_low_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [22:0] lk_h_reg;

  always_ff @(posedge core_clk_i)
    if (!rst_b_i || state_reg == ssc_pkg::S_CAL)
      lk_h_reg <= 23'h000000;
    else if (state_reg == ssc_pkg::S_LOCK)
      lk_h_reg <= lk_h_reg + 23'h000001;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_por_first: assert property ((state_reg != ssc_pkg::S_POR) |-> por_done_reg)
    else $error("sequence left reset before internal reset ended");
  a_probe_first: assert property ($fell(state_reg == ssc_pkg::S_POR) |->
    state_reg == ssc_pkg::S_START && xfer_reg == ssc_pkg::XFER_WR)
    else $error("startup did not begin with the memory probe");
  a_gpio_cfg_kept: assert property ((state_reg == ssc_pkg::S_BYTE) |=>
    $stable({cfg_mem[7], cfg_mem[6], cfg_mem[5], cfg_mem[4]}))
    else $error("memory load changed pin configuration registers");
  a_fallback_def: assert property ((state_reg == ssc_pkg::S_STOP && tick
    && q_reg == 2'h3 && !ee_ok_reg) |=> state_reg == ssc_pkg::S_DEF)
    else $error("failed load did not fall back to defaults");
  a_default_oe: assert property (($rose(state_reg == ssc_pkg::S_CAL)
    && !ee_ok_reg) |-> out_enable_o == ssc_pkg::DEF_OE[strap_reg])
    else $error("output enables differ from the strap image");
  a_cal_wait: assert property ((state_reg == ssc_pkg::S_CAL &&
    (cal_done_i & pwr) != pwr) |=> state_reg == ssc_pkg::S_CAL)
    else $error("calibration left before powered PLLs finished");
  a_lock_wait: assert property ($rose(state_reg == ssc_pkg::S_ALIGN)
    |-> lk_h_reg == 23'(LOCK_CYC))
    else $error("lock wait had the wrong length");
  a_align_len: assert property ($rose(div_reset_o) |->
    div_reset_o [*8] ##1 !div_reset_o)
    else $error("divider alignment pulse is not eight cycles");
  a_ready_mirror: assert property (status_pin_three_o ==
    init_complete_flag_o)
    else $error("ready pin differs from ready flag");
  a_strap_sample: assert property ($rose(por_done_reg) |->
    strap_reg == $past(strap_sel_i))
    else $error("straps not caught at reset release");
  a_ready_state: assert property (init_complete_flag_o |->
    state_reg == ssc_pkg::S_READY)
    else $error("ready raised before startup finished");
  a_def_full: assert property (($rose(state_reg == ssc_pkg::S_CAL)
    && !ee_ok_reg) |-> $past(idx_reg) == 4'hf)
    else $error("default image not fully written");
  a_ready_after: assert property ($rose(init_complete_flag_o) |->
    $past(div_reset_o, 2))
    else $error("ready raised without divider alignment");

  c_eeprom_load: cover property ($rose(state_reg == ssc_pkg::S_CAL)
    && ee_ok_reg);
  c_default_load: cover property ($fell(state_reg == ssc_pkg::S_DEF));
  c_ready: cover property ($rose(init_complete_flag_o));

endmodule : ssc_startup

// file: tb/ssc_eeprom_model.sv
// Behavioural serial memory that answers the sequencer's master port.
`timescale 1ns/1ps
module ssc_eeprom_model (
  input  wire logic         scl_w_i,
  input  wire logic         sda_w_i,
  input  wire logic         present_i,
  input  wire logic [135:0] image_i,
  output logic              sda_oe_o
);
  logic [7:0] shift_reg;
  logic       first;
  logic       sending;
  logic       acked;
  logic       active;
  int         cnt;
  int         idx;

  initial
  begin
    sda_oe_o = 1'b0;
    active   = 1'b0;
    first    = 1'b0;
    sending  = 1'b0;
    acked    = 1'b0;
    cnt      = 0;
    idx      = 0;
  end

  // A start or repeated start restarts byte reception; absent means mute.
  always @(negedge sda_w_i)
    if (scl_w_i === 1'b1)
    begin
      active   = present_i;
      first    = 1'b1;
      cnt      = 0;
      sending  = 1'b0;
      sda_oe_o = 1'b0;
    end

  // A stop releases the line so the pull-up returns it high.
  always @(posedge sda_w_i)
    if (scl_w_i === 1'b1)
    begin
      active   = 1'b0;
      sda_oe_o = 1'b0;
    end

  // Data and the master's acknowledge are taken while the clock is high.
  always @(posedge scl_w_i)
    if (active)
    begin
      if (cnt < 8)
        shift_reg = {shift_reg[6:0], sda_w_i};
      else
        acked = ~sda_w_i;
    end

  // The line only changes while the clock is low, as a slave must.
  always @(negedge scl_w_i)
    if (active)
    begin
      if (first)
        first = 1'b0;
      else
        cnt = cnt + 1;
      if (cnt == 9)
      begin
        cnt = 0;
        if (!sending && shift_reg == ssc_pkg::EE_ADDR_RD)
        begin
          sending = 1'b1;
          idx     = 0;
        end
        else if (sending && acked)
          idx = idx + 1;
        else if (sending)
          active = 1'b0;
      end
      if (!active)
        sda_oe_o = 1'b0;
      else if (cnt == 8)
        sda_oe_o = ~sending;
      else if (sending && idx < 17)
        sda_oe_o = ~image_i[8 * idx + 7 - cnt];
      else
        sda_oe_o = 1'b0;
    end
endmodule : ssc_eeprom_model

// file: tb/ssc_startup_bench.sv
// Self-checking bench for the startup sequencer.
`timescale 1ns/1ps
module ssc_startup_bench;
  // ----------------------------------------------------------------------
  // Stimulus, wires and measurements
  // ----------------------------------------------------------------------
  localparam int POR_N  = 20;
  localparam int LOCK_N = 10;
  localparam int QTR_N  = 4;
  logic         core_clk_i = 1'b0;
  logic         rst_b_i = 1'b0;
  logic         oscillator_supply_i = 1'b0;
  logic [1:0]   strap_sel_i = 2'h0;
  logic [2:0]   cal_done_i = 3'h0;
  logic         pll0_lock_i = 1'b0;
  logic         scl_o, scl_oe_o, sda_o, sda_oe_o, div_reset_o;
  logic [2:0]   cal_req_o, analog_pll_power_o;
  logic [15:0]  out_enable_o;
  logic         cfg_from_eeprom_o, init_complete_flag_o;
  logic         status_pin_three_o, status_pin_two_o;
  logic         mem_oe, mem_present = 1'b0;
  logic [135:0] mem_image = 136'h0;
  wire          scl_w = ~scl_oe_o;
  wire          sda_w = ~(sda_oe_o | mem_oe);
  int           miscompares = 0;
  int           n_tests = 0;
  int           t_scl, cal_last, div_first, div_len, rdy_first;
  logic [2:0]   cal_seen;
  logic         bad_copy, bad_two;

  always #2.5 core_clk_i = ~core_clk_i;

  // Calibration finishes one cycle after it is asked for.
  always @(posedge core_clk_i)
    cal_done_i <= cal_req_o;

  ssc_startup #(.POR_CYC(POR_N), .LOCK_CYC(LOCK_N), .QTR_CYC(QTR_N)) DUT (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .oscillator_supply_i(oscillator_supply_i), .strap_sel_i(strap_sel_i),
    .sda_i(sda_w), .cal_done_i(cal_done_i), .pll0_lock_i(pll0_lock_i),
    .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .cal_req_o(cal_req_o), .div_reset_o(div_reset_o),
    .out_enable_o(out_enable_o), .analog_pll_power_o(analog_pll_power_o),
    .cfg_from_eeprom_o(cfg_from_eeprom_o),
    .init_complete_flag_o(init_complete_flag_o),
    .status_pin_three_o(status_pin_three_o),
    .status_pin_two_o(status_pin_two_o));

  ssc_eeprom_model mem (
    .scl_w_i(scl_w), .sda_w_i(sda_w), .present_i(mem_present),
    .image_i(mem_image), .sda_oe_o(mem_oe));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic end_sim();
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // Resets, powers up and records when each startup step is seen.
  // The straps are flipped well after the probe starts to show they were
  // already caught.
  task automatic run_startup(input logic [1:0] s);
    int c;
    t_scl = -1;
    cal_last = -1;
    div_first = -1;
    div_len = 0;
    rdy_first = -1;
    cal_seen = 3'h0;
    bad_copy = 1'b0;
    bad_two = 1'b0;
    @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    oscillator_supply_i <= 1'b0;
    strap_sel_i <= s;
    repeat (6) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    oscillator_supply_i <= 1'b1;
    for (c = 0; c < 100000 && rdy_first < 0; c++)
    begin
      @(posedge core_clk_i);
      if (c == POR_N + 30)
        strap_sel_i <= ~s;
      pll0_lock_i <= ~pll0_lock_i;
      #1;
      if (scl_oe_o === 1'b1 && t_scl < 0)
        t_scl = c;
      if (cal_req_o !== 3'h0)
        cal_last = c;
      cal_seen = cal_seen | cal_req_o;
      if (div_reset_o === 1'b1 && div_first < 0)
        div_first = c;
      if (div_reset_o === 1'b1)
        div_len++;
      if (init_complete_flag_o === 1'b1)
        rdy_first = c;
      if (status_pin_three_o !== init_complete_flag_o)
        bad_copy = 1'b1;
      // The lock copy is held low until the internal reset has ended.
      if (c >= POR_N && status_pin_two_o !== ~pll0_lock_i)
        bad_two = 1'b1;
    end
  endtask : run_startup

  // Order and spacing of the steps that every startup shares.
  task automatic check_steps(input logic [2:0] pwr);
    chk(t_scl >= POR_N && t_scl <= POR_N + 4, "probe start time");
    chk(cal_seen === pwr, "calibrated set");
    chk(div_first - cal_last == LOCK_N + 1, "lock wait length");
    chk(div_len == 8, "align pulse length");
    chk(rdy_first == div_first + 9, "ready moment");
    chk(!bad_copy, "third pin copy");
    chk(!bad_two, "second pin status");
    chk(scl_o === 1'b0 && sda_o === 1'b0, "open-drain data");
    repeat (10) @(posedge core_clk_i);
    #1;
    chk(status_pin_three_o === 1'b1, "ready held");
  endtask : check_steps

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_default(input logic [1:0] s);
    mem_present <= 1'b0;
    run_startup(s);
    check_steps(ssc_pkg::DEF_PWR[s]);
    chk(out_enable_o === ssc_pkg::DEF_OE[s], "default enables");
    chk(analog_pll_power_o === ssc_pkg::DEF_PWR[s], "default power");
    chk(cfg_from_eeprom_o === 1'b0, "image source");
    $display("default image test done for code %0d", s);
  endtask : test_default

  // A bad checksum must leave the strap image, not the partial one.
  task automatic test_eeprom(input logic bad);
    logic [7:0] b;
    logic [7:0] sum;
    sum = 8'h00;
    for (int k = 0; k < 16; k++)
    begin
      b = (k == 0) ? 8'h5a : (k == 1) ? 8'ha5 : (k == 2) ? 8'h05
        : 8'(8'h30 + k);
      mem_image[8 * k +: 8] = b;
      sum = sum + b;
    end
    mem_image[135:128] = 8'(8'h00 - sum) + {7'h00, bad};
    mem_present <= 1'b1;
    run_startup(2'h2);
    if (bad)
    begin
      check_steps(ssc_pkg::DEF_PWR[2]);
      chk(out_enable_o === ssc_pkg::DEF_OE[2], "restored enables");
      chk(analog_pll_power_o === ssc_pkg::DEF_PWR[2], "restored pwr");
    end
    else
    begin
      check_steps(3'h5);
      chk(out_enable_o === 16'ha55a, "loaded enables");
      chk(analog_pll_power_o === 3'h5, "loaded power");
    end
    chk(cfg_from_eeprom_o === ~bad, "image source");
    $display("memory image test done, corrupt %0d", bad);
  endtask : test_eeprom

  // The bench never reconfigures anything before ready; it has no host
  // port, which keeps the host side of the startup contract.
  initial
  begin
    for (int s = 0; s < 4; s++)
      test_default(2'(s));
    test_eeprom(1'b0);
    test_eeprom(1'b1);
    end_sim();
  end

  // Two memory loads dominate, about 3000 cycles each with the short
  // quarter; 20000 cycles leave ample margin.
  initial
  begin
    #100_000;
    miscompares++;
    end_sim();
  end
endmodule : ssc_startup_bench
